// ==== hdl/xor_dir_pkg.sv ====
package xor_dir_pkg;

  // ------------------------------------------------------------
  // Instruction encodings
  // ------------------------------------------------------------
  localparam logic [5:0] OPC_XOR_LIT = 6'h3a;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  localparam logic [10:0] OPC_LOAD_DIR = 11'h00c;
  localparam int LIT_MSB = 7;
  localparam int FILE_MSB = 6;
  localparam int DEST_BIT = 7;
  localparam int DIR_SEL_MSB = 2;
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST = 3'h7;
  localparam int DIR_COUNT = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;

  // Decoded operation kinds.
  typedef enum logic [1:0] {OP_NONE, OP_XOR_LIT, OP_XOR_FILE, OP_LOAD_DIR} op_kind_t;

  // Request to write a file register back.
  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

endpackage : xor_dir_pkg

// ==== hdl/port_dir_bank.sv ====
`timescale 1ns/100ps
module port_dir_bank
  import xor_dir_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [2:0] wrSel,
  input wire logic [7:0] wrData,
  output logic [DIR_COUNT*8-1:0] dirOut
);

  logic [7:0] dirReg [DIR_COUNT];
  logic [7:0] next_dirReg [DIR_COUNT];

  // ------------------------------------------------------------
  // Direction registers, one per port
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DIR_COUNT; g++) begin : g_dir
      // Each register loads only when its own selector arrives.
      always_comb begin
        next_dirReg[g] = dirReg[g];
        if (wrEn && wrSel == DIR_FIRST + 3'(g)) begin
          next_dirReg[g] = wrData;
        end
      end
      always_ff @(posedge mclk) begin
        if (srst) begin
          dirReg[g] <= DIR_RESET;
        end else begin
          dirReg[g] <= next_dirReg[g];
        end
      end
      assign dirOut[g*8 +: 8] = dirReg[g];
    end
  endgenerate

endmodule : port_dir_bank

// ==== hdl/xor_and_direction_load_ops.sv ====
`timescale 1ns/100ps
module xor_and_direction_load_ops
  import xor_dir_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic instrValid,
  input wire logic [13:0] instr,
  input wire logic [7:0] fileRdData,
  output logic [6:0] fileRdAddr,
  output file_wr_t fileWr,
  output logic [7:0] acc,
  output logic zeroFlag,
  output logic zeroWe,
  output logic [DIR_COUNT*8-1:0] portDir
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Decoding lives in one function so the three patterns are read in one place.
  function automatic op_kind_t decode(input logic [13:0] w);
    if (w[13:8] == OPC_XOR_LIT) begin
      return OP_XOR_LIT;
    end else if (w[13:8] == OPC_XOR_FILE) begin
      return OP_XOR_FILE;
    end else if (w[13:3] == OPC_LOAD_DIR && w[2:0] >= DIR_FIRST) begin
      return OP_LOAD_DIR;
    end else begin
      return OP_NONE;
    end
  endfunction : decode

  op_kind_t op;
  logic [7:0] result;
  logic [7:0] next_acc;
  logic next_zeroFlag;
  logic next_zeroWe;
  file_wr_t next_fileWr;
  logic dirWe;

  // The read address is combinational so the file data returns in the same cycle.
  assign fileRdAddr = instr[FILE_MSB:0];
  assign op = instrValid ? decode(instr) : OP_NONE;
  assign dirWe = (op == OP_LOAD_DIR);

  // ------------------------------------------------------------
  // Execute
  // ------------------------------------------------------------
  // Operand selection and result routing for both XOR forms.
  always_comb begin
    next_acc = acc;
    next_zeroFlag = zeroFlag;
    next_zeroWe = 1'b0;
    next_fileWr = '0;
    result = 8'h00;
    case (op)
      OP_XOR_LIT: begin
        result = acc ^ instr[LIT_MSB:0];
        next_acc = result;
        next_zeroFlag = (result == 8'h00);
        next_zeroWe = 1'b1;
      end
      OP_XOR_FILE: begin
        result = acc ^ fileRdData;
        next_zeroFlag = (result == 8'h00);
        next_zeroWe = 1'b1;
        if (instr[DEST_BIT]) begin
          next_fileWr.en = 1'b1;
          next_fileWr.addr = instr[FILE_MSB:0];
          next_fileWr.data = result;
        end else begin
          next_acc = result;
        end
      end
      default: begin
      end
    endcase
  end

  // Registers only; the file write is a one-cycle registered pulse.
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc <= ACC_RESET;
      zeroFlag <= 1'b0;
      zeroWe <= 1'b0;
      fileWr <= '0;
    end else begin
      acc <= next_acc;
      zeroFlag <= next_zeroFlag;
      zeroWe <= next_zeroWe;
      fileWr <= next_fileWr;
    end
  end

  // ------------------------------------------------------------
  // Direction registers
  // ------------------------------------------------------------
  // direction load
  port_dir_bank u_dir (
    .mclk(mclk),
    .srst(srst),
    .wrEn(dirWe),
    .wrSel(instr[DIR_SEL_MSB:0]),
    .wrData(acc),
    .dirOut(portDir)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_lit;
    instrValid && instr[13:8] == OPC_XOR_LIT;
  endsequence

  sequence s_file;
    instrValid && instr[13:8] == OPC_XOR_FILE;
  endsequence

  property p_lit_acc;
    @(posedge mclk) disable iff (srst)
      s_lit |=> acc == ($past(acc) ^ $past(instr[7:0]));
  endproperty
  a_lit_acc: assert property (p_lit_acc) else $error("literal XOR accumulator wrong");

  property p_lit_zero;
    @(posedge mclk) disable iff (srst)
      s_lit |=> zeroWe && zeroFlag == (acc == 8'h00) && !fileWr.en;
  endproperty
  a_lit_zero: assert property (p_lit_zero) else $error("literal XOR zero flag wrong");

  property p_file_zero;
    @(posedge mclk) disable iff (srst)
      s_file |=> zeroWe && zeroFlag == (($past(acc) ^ $past(fileRdData)) == 8'h00);
  endproperty
  a_file_zero: assert property (p_file_zero) else $error("file XOR zero flag wrong");

  property p_file_to_acc;
    @(posedge mclk) disable iff (srst)
      s_file ##0 !instr[7] |=> acc == ($past(acc) ^ $past(fileRdData)) && !fileWr.en;
  endproperty
  a_file_to_acc: assert property (p_file_to_acc) else $error("file XOR to acc wrong");

  property p_file_to_file;
    @(posedge mclk) disable iff (srst)
      s_file ##0 instr[7] |=> fileWr.en && fileWr.addr == $past(instr[6:0])
        && fileWr.data == ($past(acc) ^ $past(fileRdData)) && acc == $past(acc);
  endproperty
  a_file_to_file: assert property (p_file_to_file) else $error("writeback wrong");

  property p_dir_load;
    @(posedge mclk) disable iff (srst)
      instrValid && instr == 14'h0067 |=> portDir[23:16] == $past(acc) && !zeroWe
        && acc == $past(acc);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

  property p_dir_quiet;
    @(posedge mclk) disable iff (srst)
      !instrValid |=> $stable(portDir) && !zeroWe && !fileWr.en;
  endproperty
  a_dir_quiet: assert property (p_dir_quiet) else $error("state moved while idle");

  // A reset edge clears the flag without a write pulse, so the edge after it is exempt.
  property p_zero_hold;
    @(posedge mclk) disable iff (srst)
      !zeroWe && !$past(srst) |-> zeroFlag == $past(zeroFlag);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved unasked");

  sequence s_dir_load;
    instrValid && instr[13:3] == OPC_LOAD_DIR;
  endsequence

  property p_dir_lane5;
    @(posedge mclk) disable iff (srst)
      s_dir_load ##0 instr[2:0] == 3'h5 |=> portDir[7:0] == $past(acc)
        && $stable(portDir[23:8]);
  endproperty
  a_dir_lane5: assert property (p_dir_lane5) else $error("lane five load wrong");

  property p_dir_lane6;
    @(posedge mclk) disable iff (srst)
      s_dir_load ##0 instr[2:0] == 3'h6 |=> portDir[15:8] == $past(acc)
        && $stable(portDir[7:0]) && $stable(portDir[23:16]);
  endproperty
  a_dir_lane6: assert property (p_dir_lane6) else $error("lane six load wrong");

  property p_dir_refused;
    @(posedge mclk) disable iff (srst)
      s_dir_load ##0 instr[2:0] < DIR_FIRST |=> $stable(portDir) && $stable(acc) && !zeroWe;
  endproperty
  a_dir_refused: assert property (p_dir_refused) else $error("refused load wrote");

  property p_other_ignored;
    @(posedge mclk) disable iff (srst)
      instrValid && instr[13:8] != OPC_XOR_LIT && instr[13:8] != OPC_XOR_FILE
        && instr[13:3] != OPC_LOAD_DIR |=> $stable(acc) && $stable(portDir) && !zeroWe
        && !fileWr.en;
  endproperty
  a_other_ignored: assert property (p_other_ignored) else $error("stray word acted");

  property p_file_wr_source;
    @(posedge mclk) disable iff (srst)
      fileWr.en |-> $past(instrValid) && $past(instr[13:8]) == OPC_XOR_FILE
        && $past(instr[7]);
  endproperty
  a_file_wr_source: assert property (p_file_wr_source) else $error("stray file write");

  property p_lit_keeps_dir;
    @(posedge mclk) disable iff (srst)
      s_lit |=> $stable(portDir) && !fileWr.en;
  endproperty
  a_lit_keeps_dir: assert property (p_lit_keeps_dir) else $error("literal moved dir");

endmodule : xor_and_direction_load_ops

// ==== tb/xor_and_direction_load_ops_tb.sv ====
`timescale 1ns/100ps
module xor_and_direction_load_ops_tb;
  import xor_dir_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] fileRdData = 8'h00;
  logic [6:0] fileRdAddr;
  file_wr_t fileWr;
  logic [7:0] acc;
  logic zeroFlag;
  logic zeroWe;
  logic [DIR_COUNT*8-1:0] portDir;
  logic [23:0] expDir;
  logic [7:0] a;
  int fails = 0;
  int compares = 0;

  xor_and_direction_load_ops dut_u (
    .mclk(mclk), .srst(srst), .instrValid(instrValid), .instr(instr),
    .fileRdData(fileRdData), .fileRdAddr(fileRdAddr), .fileWr(fileWr),
    .acc(acc), .zeroFlag(zeroFlag), .zeroWe(zeroWe), .portDir(portDir)
  );

  // Free-running clock at 250 MHz.
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  // One compare for every result; narrow values are zero extended by the caller.
  task check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Calls follow each other at falling edges, so words run back to back.
  task exec(input logic [13:0] word, input logic [7:0] rd);
    instrValid = 1'b1;
    instr = word;
    fileRdData = rd;
    #1 check({17'h0, fileRdAddr}, {17'h0, word[6:0]});
    @(posedge mclk);
    @(negedge mclk);
  endtask : exec

  task idle;
    instrValid = 1'b0;
    @(posedge mclk);
    @(negedge mclk);
  endtask : idle

  task finish_test;
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Reset values of every registered output.
  task expect_reset;
    check({16'h0, acc}, {16'h0, ACC_RESET});
    check(portDir, {DIR_COUNT{DIR_RESET}});
    check({6'h0, zeroFlag, zeroWe, fileWr}, 24'h000000);
  endtask : expect_reset

  task test_literal;
    exec(14'h3ab5, 8'h00);
    check({16'h0, acc}, 24'h0000b5);
    exec(14'h3aaf, 8'h00);
    check({16'h0, acc}, 24'h00001a);
    check({22'h0, zeroWe, zeroFlag}, 24'h000002);
    check({23'h0, fileWr.en}, 24'h000000);
    exec(14'h3a1a, 8'h00);
    check({22'h0, zeroWe, zeroFlag}, 24'h000003);
    idle;
    check({22'h0, zeroWe, zeroFlag}, 24'h000001);
    // The last word still stands, so a held accumulator proves the valid gate.
    check({16'h0, acc}, 24'h000000);
  endtask : test_literal

  // Accumulator starts at zero here; address 127 is the top of the file space.
  task test_file;
    exec(14'h3ab5, 8'h00);
    exec(14'h06a5, 8'haf);
    check({8'h0, fileWr}, {8'h0, 1'b1, 7'h25, 8'h1a});
    check({16'h0, acc}, 24'h0000b5);
    check({22'h0, zeroWe, zeroFlag}, 24'h000002);
    exec(14'h06ff, 8'hb5);
    check({8'h0, fileWr}, {8'h0, 1'b1, 7'h7f, 8'h00});
    check({22'h0, zeroWe, zeroFlag}, 24'h000003);
    exec(14'h0611, 8'h0f);
    check({16'h0, acc}, 24'h0000ba);
    check({22'h0, fileWr.en, zeroFlag}, 24'h000000);
  endtask : test_file

  // Each selector gets a fresh accumulator so a wrong lane shows up.
  task test_direction;
    a = 8'hba;
    expDir = 24'hffffff;
    for (int i = 0; i < 3; i++) begin
      a = a ^ (8'h5a + 8'(i));
      exec({6'h3a, 8'h5a + 8'(i)}, 8'h00);
      exec(14'h0065 + 14'(i), 8'h00);
      expDir[8*i +: 8] = a;
      check(portDir, expDir);
      check({23'h0, zeroWe}, 24'h000000);
    end
    exec(14'h0064, 8'h00);
    check(portDir, expDir);
    check({16'h0, acc}, {16'h0, a});
    // A word of no decoded kind must leave every result alone.
    exec(14'h0e25, 8'h3c);
    check({16'h0, acc}, {16'h0, a});
    check({22'h0, zeroWe, fileWr.en}, 24'h000000);
    idle;
  endtask : test_direction

  // One reset cycle in mid-run with the zero flag set; a word follows at once.
  task test_reset;
    exec({6'h3a, a}, 8'h00);
    check({22'h0, zeroWe, zeroFlag}, 24'h000003);
    instrValid = 1'b0;
    srst = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    expect_reset;
    exec(14'h3a3c, 8'h00);
    check({16'h0, acc}, 24'h00003c);
    idle;
  endtask : test_reset

  // Main sequence: reset until the fourth falling edge (four rising edges), then the scenarios.
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    expect_reset;
    test_literal;
    test_file;
    test_direction;
    test_reset;
    finish_test;
  end

  // Watchdog: the scenarios need well under 100 cycles.
  initial begin
    #2000;
    fails++;
    finish_test;
  end
endmodule : xor_and_direction_load_ops_tb
